/* File: hw/osb_cfg.svh */
// Register offsets, field positions and reset values of the overlay blender.
`ifndef OSB_CFG_SVH
`define OSB_CFG_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OSB_ADDR_W 16
`define OSB_OFF_XSTOP 16'h8158
`define OSB_OFF_HFILT 16'h8190
`define OSB_OFF_HSTEP 16'h8198
`define OSB_OFF_BLEND 16'h81a0
`define OSB_OFF_OPQ 16'h81dc
`define OSB_OFF_VSTEP1 16'h81e0
`define OSB_OFF_VSTEP2 16'h81e4
`define OSB_OFF_VDDA 16'h81e8
`define OSB_OFF_PSTART 16'h81f0
`define OSB_OFF_PSIZE 16'h81f4
`define OSB_OFF_SSIZE 16'h81fc
`define OSB_OFF_STATUS 16'h8300
// ****************************************************************
// Field positions
// ****************************************************************
`define OSB_FILT_HI 30
`define OSB_FILT_LO 28
`define OSB_ACC_HI 11
`define OSB_STEP1_HI 10
`define OSB_STEP2_HI 26
`define OSB_STEP2_LO 16
`define OSB_VTYPE_BIT 15
`define OSB_OPQ_EN_BIT 31
`define OSB_OPQ_TOP_BIT 30
`define OSB_STOPQ_HI 12
`define OSB_STOPQ_LO 3
`define OSB_RESTQ_HI 28
`define OSB_RESTQ_LO 19
`define OSB_MODE_HI 26
`define OSB_MODE_LO 24
`define OSB_KP_HI 12
`define OSB_KP_LO 10
`define OSB_KS_HI 4
`define OSB_KS_LO 2
`define OSB_W_HI 26
`define OSB_W_LO 16
`define OSB_H_HI 10
// ****************************************************************
// Reset values and arithmetic constants
// ****************************************************************
`define OSB_REG_RST 32'h0000_0000
`define OSB_WEIGHT_FULL 4'h8
`define OSB_QW_SHIFT 3
`endif

/* File: hw/osb_pkg.sv */
// Types shared by the overlay scale and blend block.
package osb_pkg;
  // Compose mode codes.
  typedef enum logic [2:0] {
    OSB_SEC_OVER = 3'b000,
    OSB_PRI_OVER = 3'b001,
    OSB_DISSOLVE = 3'b010,
    OSB_FADE = 3'b011,
    OSB_SEC_KEY = 3'b101,
    OSB_PRI_KEY = 3'b110
  } osb_mode_e;
  // Horizontal filter choices.
  typedef enum logic [2:0] {
    OSB_F_PASS = 3'b000,
    OSB_F_LIN024 = 3'b001,
    OSB_F_BILIN = 3'b010,
    OSB_F_LIN122 = 3'b011
  } osb_filt_e;
  typedef logic [7:0] osb_chan_t;
endpackage

/* File: hw/osb_dda.sv */
// Scaling accumulator that steps once per output pixel or line.
`timescale 1ns/1ps
module osb_dda #(
  parameter int ACC_W = 12,
  parameter int POS_W = 11
) (
  // Clocking.
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Control.
  input wire logic load,
  input wire logic step,
  input wire logic [ACC_W-1:0] seed,
  input wire logic [ACC_W-1:0] first_step_factor,
  input wire logic [ACC_W-1:0] second_step_factor,
  // Result.
  output logic [POS_W-1:0] src_pos,
  output logic advance
);
  logic [ACC_W-1:0] acc_q;
  logic [POS_W-1:0] pos_q;
  logic adv_q;

  // Negative accumulator adds the first factor and holds the source;
  // otherwise the second factor is added and the source moves on.
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q <= '0;
      pos_q <= '0;
      adv_q <= 1'b0;
    end else if (clk_en) begin
      adv_q <= 1'b0;
      if (load) begin
        acc_q <= seed;
        pos_q <= '0;
      end else if (step) begin
        if (acc_q[ACC_W-1]) begin
          acc_q <= acc_q + first_step_factor;
        end else begin
          acc_q <= acc_q + second_step_factor;
          pos_q <= pos_q + 1'b1;
          adv_q <= 1'b1;
        end
      end
    end
  end

  assign src_pos = pos_q;
  assign advance = adv_q;
endmodule

/* File: hw/osb_top.sv */
// Overlay composition: scaling steppers, fetch suppression and blending.
// Function
// - Filter field picks horizontal scaling filter only.
// - Vertical type bit: replicate or interpolate.
// - Opaque fetch enable works in opaque modes.
// - Skip fetches hidden under opaque overlay.
// - Blend RGB888 streams, then cursor overlay.
// - Dissolve mixes primary weight and eight minus.
// - Primary weight three bits, all components.
// - Fade mixes both weights over eight.
// - Secondary weight three bits, fade default black.
// - Weights take effect at next vertical sync.
// - Mode 010 selects dissolve in window.
// - Mode 011 selects fade in window.
// - Mode 000 secondary on top, 001 primary.
`timescale 1ns/1ps
`include "osb_cfg.svh"
module osb_top #(
  parameter int AW = `OSB_ADDR_W
) (
  // Clocking and reset.
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Register port.
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Display timing, from a pin.
  input wire logic vsync_pin,
  input wire logic line_start,
  input wire logic pixel_valid,
  input wire logic in_sec_window,
  input wire logic [10:0] fetch_qword,
  // Pixel streams and cursor.
  input wire logic [23:0] pri_pixel,
  input wire logic [23:0] sec_pixel,
  input wire logic [23:0] cursor_pixel,
  input wire logic cursor_valid,
  // Outputs.
  output logic [23:0] out_pixel,
  output logic out_valid,
  output logic fetch_skip,
  output logic [2:0] h_filter_sel,
  output logic v_interp,
  output logic [10:0] sec_src_x,
  output logic [10:0] sec_src_y
);
  import osb_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] xstop_q, hfilt_q, hstep_q, blend_q, opq_q;
  logic [31:0] vstep1_q, vstep2_q, vdda_q, pstart_q, psize_q, ssize_q;
  // Weights actually in use; only refreshed at vertical sync.
  logic [2:0] kp_live_q;
  logic [2:0] ks_live_q;
  // Two-stage synchroniser for the vsync pin and its edge memory.
  logic vs_m_q, vs_s_q, vs_d_q;
  logic vs_rise;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Frame counter shows block state on the status register.
  logic [15:0] frame_cnt_q;

  // Register writes; no side effects beyond storing the word.
  always_ff @(posedge clock) begin
    if (reset) begin
      xstop_q <= `OSB_REG_RST;
      hfilt_q <= `OSB_REG_RST;
      hstep_q <= `OSB_REG_RST;
      blend_q <= `OSB_REG_RST;
      opq_q <= `OSB_REG_RST;
      vstep1_q <= `OSB_REG_RST;
      vstep2_q <= `OSB_REG_RST;
      vdda_q <= `OSB_REG_RST;
      pstart_q <= `OSB_REG_RST;
      psize_q <= `OSB_REG_RST;
      ssize_q <= `OSB_REG_RST;
    end else if (clk_en && reg_write) begin
      unique case (reg_addr)
        `OSB_OFF_XSTOP: xstop_q <= reg_wdata;
        `OSB_OFF_HFILT: hfilt_q <= reg_wdata;
        `OSB_OFF_HSTEP: hstep_q <= reg_wdata;
        `OSB_OFF_BLEND: blend_q <= reg_wdata;
        `OSB_OFF_OPQ: opq_q <= reg_wdata;
        `OSB_OFF_VSTEP1: vstep1_q <= reg_wdata;
        `OSB_OFF_VSTEP2: vstep2_q <= reg_wdata;
        `OSB_OFF_VDDA: vdda_q <= reg_wdata;
        `OSB_OFF_PSTART: pstart_q <= reg_wdata;
        `OSB_OFF_PSIZE: psize_q <= reg_wdata;
        `OSB_OFF_SSIZE: ssize_q <= reg_wdata;
        default: ; // Unmapped writes are dropped.
      endcase
    end
  end

  // Read decode; unmapped addresses read as zero.
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      `OSB_OFF_XSTOP: rdata_d = xstop_q;
      `OSB_OFF_HFILT: rdata_d = hfilt_q;
      `OSB_OFF_HSTEP: rdata_d = hstep_q;
      `OSB_OFF_BLEND: rdata_d = blend_q;
      `OSB_OFF_OPQ: rdata_d = opq_q;
      `OSB_OFF_VSTEP1: rdata_d = vstep1_q;
      `OSB_OFF_VSTEP2: rdata_d = vstep2_q;
      `OSB_OFF_VDDA: rdata_d = vdda_q;
      `OSB_OFF_PSTART: rdata_d = pstart_q;
      `OSB_OFF_PSIZE: rdata_d = psize_q;
      `OSB_OFF_SSIZE: rdata_d = ssize_q;
      `OSB_OFF_STATUS: rdata_d = {10'h000, kp_live_q, ks_live_q,
                                  frame_cnt_q};
      default: rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (clk_en) begin
      rdata_q <= reg_read ? rdata_d : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Vertical sync and weight latching
  // ****************************************************************
  // The vsync pin is asynchronous, so only the second stage is used.
  always_ff @(posedge clock) begin
    if (reset) begin
      vs_m_q <= 1'b0;
      vs_s_q <= 1'b0;
      vs_d_q <= 1'b0;
    end else if (clk_en) begin
      vs_m_q <= vsync_pin;
      vs_s_q <= vs_m_q;
      vs_d_q <= vs_s_q;
    end
  end
  assign vs_rise = vs_s_q && !vs_d_q;

  // Weights move to the live copy only at vsync, so a mid-frame
  // rewrite never tears the picture.
  always_ff @(posedge clock) begin
    if (reset) begin
      kp_live_q <= 3'h0;
      ks_live_q <= 3'h0;
      frame_cnt_q <= 16'h0000;
    end else if (clk_en && vs_rise) begin
      kp_live_q <= blend_q[`OSB_KP_HI:`OSB_KP_LO];
      ks_live_q <= blend_q[`OSB_KS_HI:`OSB_KS_LO];
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Scaling steppers
  // ****************************************************************
  logic [10:0] hpos, vpos;

  // Horizontal: step per output pixel inside the window, reseed each
  // line. The factors are sign-extended from eleven bits.
  osb_dda #(.ACC_W(12), .POS_W(11)) u_hdda (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .load(line_start),
    .step(pixel_valid && in_sec_window),
    .seed(hfilt_q[`OSB_ACC_HI:0]),
    .first_step_factor({hstep_q[`OSB_STEP1_HI], hstep_q[`OSB_STEP1_HI:0]}),
    .second_step_factor({hstep_q[`OSB_STEP2_HI],
                         hstep_q[`OSB_STEP2_HI:`OSB_STEP2_LO]}),
    .src_pos(hpos),
    .advance()
  );

  // Vertical: step per output line, reseed each frame.
  osb_dda #(.ACC_W(12), .POS_W(11)) u_vdda (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .load(vs_rise),
    .step(line_start),
    .seed(vdda_q[`OSB_ACC_HI:0]),
    .first_step_factor({vstep1_q[`OSB_STEP1_HI], vstep1_q[`OSB_STEP1_HI:0]}),
    .second_step_factor({vstep2_q[`OSB_STEP1_HI],
                         vstep2_q[`OSB_STEP1_HI:0]}),
    .src_pos(vpos),
    .advance()
  );

  // Scaler controls go out registered; filter only shapes horizontal.
  always_ff @(posedge clock) begin
    if (reset) begin
      h_filter_sel <= OSB_F_PASS;
      v_interp <= 1'b0;
      sec_src_x <= '0;
      sec_src_y <= '0;
    end else if (clk_en) begin
      h_filter_sel <= hfilt_q[`OSB_FILT_HI:`OSB_FILT_LO];
      v_interp <= vdda_q[`OSB_VTYPE_BIT];
      sec_src_x <= hpos;
      sec_src_y <= vpos;
    end
  end

  // ****************************************************************
  // Opaque overlay fetch suppression
  // ****************************************************************
  osb_mode_e mode;
  logic opaque_mode;
  assign mode = osb_mode_e'(blend_q[`OSB_MODE_HI:`OSB_MODE_LO]);
  assign opaque_mode = (mode == OSB_SEC_OVER) || (mode == OSB_PRI_OVER);

  // Background quadwords from stop up to but not including restart are skipped. The
  // enable is honoured only in the opaque modes, which also guards
  // against software leaving it set while blending or keying.
  always_ff @(posedge clock) begin
    if (reset) begin
      fetch_skip <= 1'b0;
    end else if (clk_en) begin
      fetch_skip <= opq_q[`OSB_OPQ_EN_BIT] && opaque_mode &&
        ({1'b0, fetch_qword[9:0]} >=
         {1'b0, opq_q[`OSB_STOPQ_HI:`OSB_STOPQ_LO]}) &&
        ({1'b0, fetch_qword[9:0]} <
         {1'b0, opq_q[`OSB_RESTQ_HI:`OSB_RESTQ_LO]});
    end
  end

  // ****************************************************************
  // Blender
  // ****************************************************************
  logic [23:0] mix;
  logic [3:0] wp, ws;

  // Weights per mode; dissolve takes eight minus the primary weight.
  always_comb begin
    wp = {1'b0, kp_live_q};
    ws = {1'b0, ks_live_q};
    if (mode == OSB_DISSOLVE) begin
      ws = `OSB_WEIGHT_FULL - {1'b0, kp_live_q};
    end
  end

  // Two products per colour byte; each is at most 8 x 255, 11 bits.
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [11:0] sum;
    // Both operands are widened first, so no product bit is lost.
    assign sum = {4'h0, pri_pixel[c*8 +: 8]} * {8'h00, wp} +
                 {4'h0, sec_pixel[c*8 +: 8]} * {8'h00, ws};
    assign mix[c*8 +: 8] = sum[10:`OSB_QW_SHIFT];
  end

  // Stream select and cursor overlay, one cycle of latency.
  always_ff @(posedge clock) begin
    if (reset) begin
      out_pixel <= '0;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      out_valid <= pixel_valid;
      if (cursor_valid) begin
        out_pixel <= cursor_pixel;
      end else if (!in_sec_window) begin
        out_pixel <= pri_pixel;
      end else begin
        unique case (mode)
          OSB_DISSOLVE, OSB_FADE: out_pixel <= mix;
          OSB_PRI_OVER: out_pixel <= pri_pixel;
          default: out_pixel <= sec_pixel;
        endcase
      end
    end
  end
endmodule

/* File: testbench/osb_disp_model.sv */
// Display timing model that feeds frame sync and line start to the block.
`timescale 1ns/1ps
module osb_disp_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Frame request from the bench.
  input wire logic frame_go,
  // Timing towards the block.
  output logic vsync_pin,
  output logic line_start
);
  // Countdown through one short frame; zero means idle.
  logic [3:0] cnt_q;
  // Sync is held four cycles so the two-stage synchroniser cannot miss
  // it; four lines follow, so the vertical stepper really advances.
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= 4'h0;
    end else if (frame_go) begin
      cnt_q <= 4'hc;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Line starts come every other cycle once sync has fallen.
  assign vsync_pin = cnt_q > 4'h8;
  assign line_start = cnt_q[0] && cnt_q < 4'h8;
endmodule

/* File: testbench/osb_top_monitor.sv */
// Concurrent checks on the ports of the overlay blender.
`timescale 1ns/1ps
`include "osb_cfg.svh"
module osb_top_monitor #(
  parameter int AW = 16
) (
  // Clocking.
  input wire logic clock,
  input wire logic reset,
  // Register port.
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Streams.
  input wire logic pixel_valid,
  input wire logic in_sec_window,
  input wire logic [10:0] fetch_qword,
  input wire logic [23:0] pri_pixel,
  input wire logic [23:0] sec_pixel,
  input wire logic [23:0] cursor_pixel,
  input wire logic cursor_valid,
  // Results.
  input wire logic [23:0] out_pixel,
  input wire logic out_valid,
  input wire logic fetch_skip,
  input wire logic [2:0] h_filter_sel,
  input wire logic v_interp,
  input wire logic [10:0] sec_src_x
);
  // Shadow of compose mode and opaque fetch fields.
  logic [2:0] mode_q;
  logic en_q;
  logic [9:0] stop_q, rest_q;
  // Follow register writes so the checks know the live mode.
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q <= 3'h0;
      en_q <= 1'b0;
      stop_q <= 10'h0;
      rest_q <= 10'h0;
    end else if (reg_write && reg_addr == `OSB_OFF_BLEND) begin
      mode_q <= reg_wdata[26:24];
    end else if (reg_write && reg_addr == `OSB_OFF_OPQ) begin
      en_q <= reg_wdata[31];
      stop_q <= reg_wdata[12:3];
      rest_q <= reg_wdata[28:19];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  valid_delay_a: assert property (1'b1 |=> out_valid == $past(pixel_valid))
    else $error("output valid not one cycle after input");
  filter_sel_a: assert property (
    reg_write && reg_addr == `OSB_OFF_HFILT
    |-> ##2 h_filter_sel == $past(reg_wdata[30:28], 2))
    else $error("filter select not from its field");
  vert_type_a: assert property (
    reg_write && reg_addr == `OSB_OFF_VDDA
    |-> ##2 v_interp == $past(reg_wdata[15], 2))
    else $error("vertical type not from bit 15");
  cursor_top_a: assert property (
    pixel_valid && cursor_valid |=> out_pixel == $past(cursor_pixel))
    else $error("cursor not on top");
  outside_pri_a: assert property (
    pixel_valid && !cursor_valid && !in_sec_window
    |=> out_pixel == $past(pri_pixel))
    else $error("primary not shown outside window");
  opaque_pick_a: assert property (
    pixel_valid && !cursor_valid && in_sec_window && mode_q[2:1] == 2'h0
    |=> out_pixel == $past(mode_q[0] ? pri_pixel : sec_pixel))
    else $error("wrong stream on top");
  opaque_skip_a: assert property (
    1'b1 |=> fetch_skip == $past(en_q &&
    mode_q[2:1] == 2'h0 && stop_q <= fetch_qword[9:0] &&
    fetch_qword[9:0] < rest_q))
    else $error("fetch skip mismatch");
  dda_step_a: assert property ($changed(sec_src_x) |->
    sec_src_x == $past(sec_src_x) + 11'h1 || sec_src_x == 11'h0)
    else $error("source position jumped");
  cover property (pixel_valid && in_sec_window && mode_q == 3'h2);
  cover property (pixel_valid && in_sec_window && mode_q == 3'h3);
  cover property (fetch_skip);
endmodule
bind osb_top osb_top_monitor #(.AW(AW)) mon (.clock(clock), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .pixel_valid(pixel_valid),
  .in_sec_window(in_sec_window), .fetch_qword(fetch_qword),
  .pri_pixel(pri_pixel), .sec_pixel(sec_pixel), .cursor_pixel(cursor_pixel),
  .cursor_valid(cursor_valid), .out_pixel(out_pixel), .out_valid(out_valid),
  .fetch_skip(fetch_skip), .h_filter_sel(h_filter_sel),
  .v_interp(v_interp), .sec_src_x(sec_src_x));

/* File: testbench/osb_top_tb.sv */
// Self-checking bench for the overlay scale and blend block.
`timescale 1ns/1ps
`include "osb_cfg.svh"
module osb_top_tb;
  // Bench-driven inputs.
  logic clock = 0, reset = 1, clk_en = 1, frame_go = 0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_write = 0, reg_read = 0, vsync_pin, line_start;
  logic pixel_valid = 0, in_sec_window = 0, cursor_valid = 0;
  logic [10:0] fetch_qword = 11'h0, sec_src_x, sec_src_y;
  logic [23:0] pri_pixel = 24'h0, sec_pixel = 24'h0, cursor_pixel = 24'h0;
  logic [23:0] out_pixel;
  logic out_valid, fetch_skip, v_interp;
  logic [2:0] h_filter_sel;
  int n_fail = 0, n_tests = 0;
  always #2.5 clock = ~clock;
  osb_top DUT (.clock(clock), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .vsync_pin(vsync_pin),
    .line_start(line_start), .pixel_valid(pixel_valid),
    .in_sec_window(in_sec_window), .fetch_qword(fetch_qword),
    .pri_pixel(pri_pixel), .sec_pixel(sec_pixel),
    .cursor_pixel(cursor_pixel), .cursor_valid(cursor_valid),
    .out_pixel(out_pixel), .out_valid(out_valid), .fetch_skip(fetch_skip),
    .h_filter_sel(h_filter_sel), .v_interp(v_interp),
    .sec_src_x(sec_src_x), .sec_src_y(sec_src_y));
  osb_disp_model far (.clock(clock), .reset(reset), .frame_go(frame_go),
    .vsync_pin(vsync_pin), .line_start(line_start));
  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // One-cycle read; data is only valid in the following cycle.
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // One pixel in the window, checked at the edge after it.
  task automatic px(input logic [23:0] p, s, input logic cv,
    input logic [23:0] e);
    @(posedge clock);
    pixel_valid <= 1'b1;
    in_sec_window <= 1'b1;
    pri_pixel <= p;
    sec_pixel <= s;
    cursor_pixel <= 24'h13579b;
    cursor_valid <= cv;
    @(posedge clock);
    pixel_valid <= 1'b0;
    cursor_valid <= 1'b0;
    #1 chk(out_pixel, e);
  endtask
  // Weighted mix per channel, truncated by the divide by eight.
  function automatic logic [23:0] mix(input logic [23:0] p, s,
    input int kp, ks);
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      r[8*i+:8] = 8'((p[8*i+:8] * kp + s[8*i+:8] * ks) >> 3);
    end
    return r;
  endfunction
  // A frame start; the wait covers sync and the four line starts that follow.
  task automatic frame();
    @(posedge clock);
    frame_go <= 1'b1;
    @(posedge clock);
    frame_go <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  // Register map: zero after reset, full readback, unmapped reads zero.
  task automatic t_regs();
    logic [15:0] map [11] = '{`OSB_OFF_XSTOP, `OSB_OFF_HFILT, `OSB_OFF_HSTEP,
      `OSB_OFF_BLEND, `OSB_OFF_OPQ, `OSB_OFF_VSTEP1, `OSB_OFF_VSTEP2,
      `OSB_OFF_VDDA, `OSB_OFF_PSTART, `OSB_OFF_PSIZE, `OSB_OFF_SSIZE};
    foreach (map[i]) begin
      rd(map[i], 32'h0);
      wr(map[i], {map[i], ~map[i]});
      rd(map[i], {map[i], ~map[i]});
    end
    wr(16'h8004, 32'hffff_ffff);
    rd(16'h8004, 32'h0);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  endtask
  // Filter codes and vertical type reach their outputs.
  task automatic t_filter();
    for (int f = 0; f < 4; f++) begin
      wr(`OSB_OFF_HFILT, 32'(f) << 28);
      repeat (2) @(posedge clock);
      chk(h_filter_sel, 32'(f));
    end
    wr(`OSB_OFF_VDDA, 32'h0000_8000);
    repeat (2) @(posedge clock);
    chk(v_interp, 1);
  endtask
  // Blend modes, weights held until frame start, cursor above all.
  task automatic t_blend();
    logic [23:0] p = 24'hf0_80_38, s = 24'h1c_ff_a0;
    wr(`OSB_OFF_BLEND, 32'h0300_0000);
    px(p, s, 0, 24'h0);
    px(p, s, 1, 24'h13579b);
    wr(`OSB_OFF_BLEND, 32'h0200_1400);
    px(p, s, 0, s);
    for (int k = 0; k < 8; k++) begin
      wr(`OSB_OFF_BLEND, 32'h0200_0000 | (32'(k) << 10));
      frame();
      px(p, s, 0, mix(p, s, k, 8 - k));
    end
    wr(`OSB_OFF_BLEND, 32'h0300_0c10);
    frame();
    px(p, s, 0, mix(p, s, 3, 4));
    rd(`OSB_OFF_STATUS, 32'h001c_0009);
    wr(`OSB_OFF_BLEND, 32'h0000_0000);
    px(p, s, 0, s);
    wr(`OSB_OFF_BLEND, 32'h0100_0000);
    px(p, s, 0, p);
  endtask
  // Fetches between stop and restart are skipped in both opaque modes; dissolve runs with the enable clear.
  task automatic t_opaque();
    logic [31:0] w;
    for (int m = 0; m < 3; m++) begin
      // Enable only in the opaque modes; top bit set for primary on top.
      w = 32'h0040_0020 | 32'(m < 2) << 31 | 32'(m == 1) << 30;
      wr(`OSB_OFF_OPQ, w);
      wr(`OSB_OFF_BLEND, 32'(m) << 24);
      for (int q = 2; q < 10; q++) begin
        @(posedge clock);
        fetch_qword <= 11'(q);
        @(posedge clock);
        #1 chk(fetch_skip, m < 2 && q >= 4 && q < 8);
      end
    end
  endtask
  // Horizontal stepper for a 10 to 25 pixel stretch.
  task automatic t_dda();
    int acc = -6, pos = 0;
    wr(`OSB_OFF_HFILT, 32'h0000_0ffa);
    wr(`OSB_OFF_HSTEP, 32'h07f1_0009);
    frame();
    @(posedge clock);
    pixel_valid <= 1'b1;
    in_sec_window <= 1'b1;
    repeat (25) @(posedge clock);
    pixel_valid <= 1'b0;
    for (int i = 0; i < 25; i++) begin
      pos += acc < 0 ? 0 : 1;
      acc += acc < 0 ? 9 : -15;
    end
    repeat (3) @(posedge clock);
    chk(sec_src_x, pos);
  endtask
  // Vertical stepper for a 2 to 4 line stretch over the four lines.
  task automatic t_vert();
    int acc = -3, pos = 0;
    wr(`OSB_OFF_VSTEP1, 32'h0000_0001);
    wr(`OSB_OFF_VSTEP2, 32'h0000_07fe);
    wr(`OSB_OFF_VDDA, 32'h0000_0ffd);
    frame();
    for (int i = 0; i < 4; i++) begin
      pos += acc < 0 ? 0 : 1;
      acc += acc < 0 ? 1 : -2;
    end
    repeat (2) @(posedge clock);
    chk(sec_src_y, pos);
  endtask
  // Verdict, reached by the main sequence or by the watchdog.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_filter();
    t_blend();
    t_opaque();
    t_dda();
    t_vert();
    complete_run();
  end
  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    complete_run();
  end
endmodule
